/* rtl/efc_consts.svh */
// Offsets, codes, CRC polynomial, reset values and timing constants for the function command block
`ifndef EFC_CONSTS_SVH
`define EFC_CONSTS_SVH
`define EFC_CMD_ADDR 8'hFE
`define EFC_ID_ADDR 8'hF0
`define EFC_ID_LAST 8'hF7
`define EFC_COPY0 8'h42
`define EFC_COPY1 8'h44
`define EFC_COPY2 8'h48
`define EFC_RCL0 8'hB2
`define EFC_RCL1 8'hB4
`define EFC_RCL2 8'hB8
`define EFC_LOCK0 8'h63
`define EFC_LOCK1 8'h66
`define EFC_LOCK2 8'h6A
`define EFC_CRC_POLY_REV 8'h8C
`define EFC_PROG_TIME_NS 2000000
`define EFC_CLK_PERIOD_NS 100
`define EFC_PROG_CYCLES (`EFC_PROG_TIME_NS / `EFC_CLK_PERIOD_NS)
`define EFC_FAMILY_RST 8'h5A
`define EFC_FIXED_RST 8'hA5
`endif

/* rtl/efc_pkg.sv */
// Types shared by the function command block
package efc_pkg;
	typedef enum logic [1:0] {
		EFC_IDLE = 2'b00,
		EFC_PROG = 2'b01
	} efc_state_t;
	typedef enum logic [1:0] {
		EFC_OP_NONE = 2'b00,
		EFC_OP_COPY = 2'b01,
		EFC_OP_RECALL = 2'b10,
		EFC_OP_LOCK = 2'b11
	} efc_op_t;
endpackage

/* rtl/efc_core.sv */
// EEPROM function command executor and read-only factory ID
// What this block does
// - Command is a one-byte write to address FEh carrying the function code.
// - Codes 42h, 44h, 48h copy shadow RAM into EEPROM block 0, 1, 2.
// - Copy to an already locked block is discarded.
// - Copy-busy flag stays 1 for the whole copy, cleared when done.
// - During a copy, writes starting inside the target block are ignored.
// - During a copy, accesses starting outside the target block proceed.
// - Copy starts after code acknowledge and lasts about 2 ms.
// - Codes B2h, B4h, B8h recall EEPROM block 0, 1, 2 into shadow RAM.
// - Codes 63h, 66h, 6Ah write-protect EEPROM block 0, 1, 2.
// - Lock acts only when lock-arm bit is 1, else no-operation.
// - A lock is permanent; later programming of that block is refused.
// - Lock starts after code acknowledge and lasts about 2 ms.
// - ID-fitted variants have no block 2; commands to it do nothing.
// - ID byte 0 holds the family code.
// - Next 48 bits hold a 40-bit serial then a fixed byte.
// - Last ID byte is a CRC over the first 56 bits.
// - ID reads as eight bytes from F0h with auto-increment.
// - ID is read-only; writes leave it unchanged.
// - Extra data bytes after the code are dropped; reading FEh is undefined.
// - Writes to unlocked blocks touch shadow RAM only; EEPROM changes on copy.
`timescale 1ns/1ns
`include "efc_consts.svh"
module efc_core #(
	parameter int PROG_CYCLES = `EFC_PROG_CYCLES,
	parameter bit HAS_UID = 1'b0,
	parameter logic [7:0] FAMILY_CODE = `EFC_FAMILY_RST, // Arbitrary value
	parameter logic [39:0] SERIAL = 40'h0123456789,
	parameter logic [7:0] FIXED_BYTE = `EFC_FIXED_RST, // Arbitrary value
	parameter logic [7:0] BLK_START0 = 8'h20,
	parameter logic [7:0] BLK_START1 = 8'h30,
	parameter logic [7:0] BLK_START2 = 8'h40,
	parameter logic [7:0] BLK_SIZE = 8'h10
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	// Byte write strobes from the serial engine
	input wire logic wr_first_i,
	input wire logic wr_byte_i,
	input wire logic [7:0] memory_pointer_i,
	input wire logic [7:0] wr_data_i,
	input wire logic stop_i,
	// Read port
	input wire logic [7:0] rd_addr_i,
	output logic [7:0] rd_data_o,
	output logic rd_hit_o,
	// Lock arm bit and shadow write gate
	input wire logic lock_arm_i,
	output logic wr_block_o,
	// Non-volatile status and operations
	output logic nv_copy_busy_o,
	output logic [2:0] locked_o,
	output logic [2:0] copy_req_o,
	output logic [2:0] recall_req_o
);
	import efc_pkg::*;

	efc_state_t state_q, state_d;
	efc_op_t op_q;
	logic [1:0] blk_q;
	logic [31:0] cnt_q;
	logic [2:0] locked_q;
	logic [7:0] code_q;
	logic code_pend_q;
	logic code_seen_q;
	logic [2:0] copy_q, recall_q;
	logic wr_block_q;
	logic [7:0] rd_data_q;
	logic rd_hit_q;

	// Next values of the registers
	efc_op_t op_d;
	logic [1:0] tgt_blk_d;
	logic [31:0] cnt_d;
	logic [2:0] locked_d;
	logic [2:0] copy_d;
	logic [2:0] recall_d;
	logic [7:0] code_d;
	logic code_pend_d;
	logic code_seen_d;
	logic tgt_busy_q;
	logic tgt_busy_d;

	// Sequencer strobes
	wire start_prog;
	wire prog_last;
	wire lock_done;
	wire copy_done;
	wire code_take;
	efc_op_t busy_op;

	// Decode of the latched function code
	wire efc_op_t dec_op;
	wire [1:0] dec_blk;
	wire blk_ok;
	wire is_copy0 = (code_q == `EFC_COPY0);
	wire is_copy1 = (code_q == `EFC_COPY1);
	wire is_copy2 = (code_q == `EFC_COPY2);
	wire is_rcl0 = (code_q == `EFC_RCL0);
	wire is_rcl1 = (code_q == `EFC_RCL1);
	wire is_rcl2 = (code_q == `EFC_RCL2);
	wire is_lck0 = (code_q == `EFC_LOCK0);
	wire is_lck1 = (code_q == `EFC_LOCK1);
	wire is_lck2 = (code_q == `EFC_LOCK2);
	wire any_copy = is_copy0 | is_copy1 | is_copy2;
	wire any_rcl = is_rcl0 | is_rcl1 | is_rcl2;
	wire any_lck = is_lck0 | is_lck1 | is_lck2;
	assign dec_op = any_copy ? EFC_OP_COPY
		: any_rcl ? EFC_OP_RECALL
		: any_lck ? EFC_OP_LOCK
		: EFC_OP_NONE;
	assign dec_blk = (is_copy0 | is_rcl0 | is_lck0) ? 2'd0
		: (is_copy1 | is_rcl1 | is_lck1) ? 2'd1
		: 2'd2;
	assign blk_ok = !(HAS_UID && dec_blk == 2'd2);
	wire tgt_locked = locked_q[dec_blk];
	wire go_copy = (dec_op == EFC_OP_COPY) && blk_ok && !tgt_locked;
	wire go_lock = (dec_op == EFC_OP_LOCK) && blk_ok && lock_arm_i && !tgt_locked;
	wire go_rcl = (dec_op == EFC_OP_RECALL) && blk_ok;
	// A code is executed at stop; programming ignores new codes until done
	wire exec = code_pend_q && stop_i && state_q == EFC_IDLE;

	// Incoming byte classification
	wire cmd_first = wr_first_i && memory_pointer_i == `EFC_CMD_ADDR;
	wire [7:0] base_sel = (blk_q == 2'd0) ? BLK_START0
		: (blk_q == 2'd1) ? BLK_START1 : BLK_START2;
	wire [7:0] rel = memory_pointer_i - base_sel;
	// Offset wraps below the block start, so one compare covers both ends
	wire in_tgt = rel < BLK_SIZE;
	wire tgt_busy = (state_q == EFC_PROG) && (op_q == EFC_OP_COPY);
	wire id_hit = (memory_pointer_i >= `EFC_ID_ADDR) && (memory_pointer_i <= `EFC_ID_LAST);
	wire in_l0 = (memory_pointer_i - BLK_START0) < BLK_SIZE;
	wire in_l1 = (memory_pointer_i - BLK_START1) < BLK_SIZE;
	wire in_l2 = (memory_pointer_i - BLK_START2) < BLK_SIZE;
	wire in_locked = (in_l0 && locked_q[0])
		|| (in_l1 && locked_q[1])
		|| (in_l2 && locked_q[2]);
	// Gate applies to the whole write from its first byte
	wire first_blk = (tgt_busy && in_tgt) || id_hit || in_locked;
	wire next_blk = wr_byte_i ? (wr_block_q || id_hit) : wr_block_q;
	wire blk_d = wr_first_i ? first_blk : next_blk;

	// CRC over the seven leading ID bytes, lsb first
	function automatic logic [7:0] efc_crc(input logic [55:0] d);
		logic [7:0] c;
		logic fb;
		c = 8'h00;
		fb = 1'b0;
		for (int i = 0; i < 56; i++)
		begin
			fb = c[0] ^ d[i];
			c = (c >> 1) ^ (fb ? `EFC_CRC_POLY_REV : 8'h00);
		end
		return c;
	endfunction
	// Byte 0 family at lsb side, serial next, fixed byte, then CRC
	wire [55:0] id_body = {FIXED_BYTE, SERIAL, FAMILY_CODE};
	wire [63:0] id_word = {efc_crc(id_body), id_body};
	wire [2:0] id_idx = rd_addr_i[2:0];
	wire rd_id = HAS_UID && (rd_addr_i >= `EFC_ID_ADDR) && (rd_addr_i <= `EFC_ID_LAST);
	// Reads of FEh give no defined value; FFh is returned
	wire [7:0] rd_val = rd_id ? id_word[{id_idx, 3'b000} +: 8] : 8'hFF;

	// Programming sequencer
	assign start_prog = (state_q == EFC_IDLE) && (state_d == EFC_PROG);
	assign prog_last = (state_q == EFC_PROG) && (cnt_q == 32'd1);
	assign lock_done = prog_last && (op_q == EFC_OP_LOCK);
	assign copy_done = prog_last && (op_q == EFC_OP_COPY);
	// Loaded on entry so the busy window is exactly PROG_CYCLES long
	assign cnt_d = start_prog ? 32'(PROG_CYCLES)
		: (state_q == EFC_PROG) ? cnt_q - 32'd1
		: cnt_q;
	assign op_d = start_prog ? dec_op : op_q;
	assign tgt_blk_d = start_prog ? dec_blk : blk_q;

	always_comb
	begin
		state_d = state_q;
		case (state_q)
			EFC_IDLE:
				if (exec && (go_copy || go_lock))
					state_d = EFC_PROG;
			EFC_PROG:
				if (cnt_q == 32'd1)
					state_d = EFC_IDLE;
			default:
				state_d = EFC_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			state_q <= EFC_IDLE;
		else
			state_q <= state_d;
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			cnt_q <= 32'd0;
		else
			cnt_q <= cnt_d;
	end

	// Operation and block stay frozen for the whole programming cycle
	always_ff @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			op_q <= EFC_OP_NONE;
		else
			op_q <= op_d;
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			blk_q <= 2'd0;
		else
			blk_q <= tgt_blk_d;
	end

	// Only the first data byte after an FEh pointer is kept
	assign code_take = wr_byte_i && code_seen_q && !code_pend_q;
	assign code_d = code_take ? wr_data_i : code_q;
	assign code_pend_d = wr_first_i ? 1'b0
		: code_take ? 1'b1
		: stop_i ? 1'b0
		: code_pend_q;
	// A repeated start with another pointer cancels a half-sent command
	assign code_seen_d = wr_first_i ? cmd_first
		: stop_i ? 1'b0
		: code_seen_q;

	always_ff @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			code_q <= 8'h00;
		else
			code_q <= code_d;
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			code_pend_q <= 1'b0;
		else
			code_pend_q <= code_pend_d;
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			code_seen_q <= 1'b0;
		else
			code_seen_q <= code_seen_d;
	end

	// Lock bits only ever set; nothing but reset clears them
	assign locked_d = lock_done
		? (locked_q | (3'b001 << blk_q))
		: locked_q;

	always_ff @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			locked_q <= 3'b000;
		else
			locked_q <= locked_d;
	end

	// Copy commits at end of programming; shadow writes reach EEPROM only through a copy
	assign copy_d = copy_done ? (3'b001 << blk_q)
		: 3'b000;
	// Recall needs no programming time, so it fires straight from the stop
	assign recall_d = (exec && go_rcl) ? (3'b001 << dec_blk)
		: 3'b000;

	always_ff @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			copy_q <= 3'b000;
		else
			copy_q <= copy_d;
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			recall_q <= 3'b000;
		else
			recall_q <= recall_d;
	end

	// Busy covers copies only; a lock keeps the sequencer busy silently
	assign busy_op = (state_q == EFC_PROG) ? op_q : dec_op;
	assign tgt_busy_d = (state_d == EFC_PROG) && (busy_op == EFC_OP_COPY);

	always_ff @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			tgt_busy_q <= 1'b0;
		else
			tgt_busy_q <= tgt_busy_d;
	end

	// Write gate for the shadow RAM
	always_ff @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			wr_block_q <= 1'b0;
		else
			wr_block_q <= blk_d;
	end

	// Read data is registered; the engine asks for a byte one cycle ahead
	always_ff @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			rd_data_q <= 8'hFF;
		else
			rd_data_q <= rd_val;
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			rd_hit_q <= 1'b0;
		else
			rd_hit_q <= rd_id;
	end

	// Every output comes straight from a flip-flop
	assign rd_data_o = rd_data_q;
	assign rd_hit_o = rd_hit_q;
	assign wr_block_o = wr_block_q;
	assign nv_copy_busy_o = tgt_busy_q;
	assign locked_o = locked_q;
	assign copy_req_o = copy_q;
	assign recall_req_o = recall_q;
endmodule

/* test/efc_checker.sv */
// Port assertions for the function command block
`timescale 1ns/1ns
`include "efc_consts.svh"
module efc_checker (
	// Clock, reset and strobes
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic wr_first_i,
	input wire logic wr_byte_i,
	input wire logic [7:0] memory_pointer_i,
	input wire logic [7:0] wr_data_i,
	input wire logic stop_i,
	input wire logic lock_arm_i,
	input wire logic [7:0] rd_addr_i,
	// Outputs
	input wire logic rd_hit_o,
	input wire logic nv_copy_busy_o,
	input wire logic [2:0] locked_o,
	input wire logic [2:0] copy_req_o,
	input wire logic [2:0] recall_req_o
);
	logic [7:0] code_q;
	logic [7:0] code_d;
	wire logic hit = wr_byte_i && memory_pointer_i == `EFC_CMD_ADDR;
	wire logic go = stop_i && !nv_copy_busy_o;
	wire logic cp = |copy_req_o;
	wire logic id = rd_addr_i >= `EFC_ID_ADDR && rd_addr_i <= `EFC_ID_LAST;
	assign code_d = wr_first_i ? 8'h00 : hit ? wr_data_i : code_q;
	always_ff @(posedge ref_clk_i or negedge rstn_i)
		if (!rstn_i)
			code_q <= 8'h00;
		else
			code_q <= code_d;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rstn_i);
	chk_copy_start: assert property (go && code_q == `EFC_COPY0 && !locked_o[0] |=> nv_copy_busy_o)
		else $error("copy did not start");
	chk_busy_hold: assert property ($rose(nv_copy_busy_o) |-> nv_copy_busy_o[*8])
		else $error("busy dropped early");
	chk_copy_commit: assert property ($rose(nv_copy_busy_o) |-> ##[9:12] cp)
		else $error("no commit pulse");
	chk_busy_end: assert property ($fell(nv_copy_busy_o) |-> cp)
		else $error("busy fell without commit");
	chk_locked_drop: assert property (go && code_q == `EFC_COPY0 && locked_o[0] |=> !nv_copy_busy_o[*2])
		else $error("copy to locked block ran");
	chk_lock_keep: assert property ((locked_o & $past(locked_o)) == $past(locked_o))
		else $error("lock bit cleared");
	chk_lock_unarmed: assert property (go && code_q == `EFC_LOCK0 && !lock_arm_i |=> $stable(locked_o)[*8])
		else $error("unarmed lock acted");
	chk_recall_pulse: assert property (go && code_q == `EFC_RCL1 |=> recall_req_o == 3'h2 ##1 recall_req_o == 3'h0)
		else $error("recall pulse wrong");
	chk_id_hit: assert property (id |=> rd_hit_o)
		else $error("id byte not served");
	cover property ($rose(nv_copy_busy_o));
	cover property ($rose(locked_o[0]));
	cover property (rd_hit_o);
endmodule

/* test/efc_master.sv */
// Serial engine stand-in issuing pointer, data and stop strobes
`timescale 1ns/1ns
module efc_master (
	// Clock
	input wire logic ref_clk_i,
	// Strobes
	output logic wr_first_o,
	output logic wr_byte_o,
	output logic [7:0] memory_pointer_o,
	output logic [7:0] wr_data_o,
	output logic stop_o
);
	initial
	begin
		wr_first_o = 1'b0;
		wr_byte_o = 1'b0;
		memory_pointer_o = 8'h00;
		wr_data_o = 8'h00;
		stop_o = 1'b0;
	end
	task automatic write(input logic [7:0] ptr, input logic [7:0] d0, input logic [7:0] d1, input bit two);
		@(posedge ref_clk_i);
		wr_first_o <= 1'b1;
		memory_pointer_o <= ptr;
		@(posedge ref_clk_i);
		wr_first_o <= 1'b0;
		wr_byte_o <= 1'b1;
		wr_data_o <= d0;
		if (two)
		begin
			@(posedge ref_clk_i);
			memory_pointer_o <= ptr + 8'h01;
			wr_data_o <= d1;
		end
		@(posedge ref_clk_i);
		wr_byte_o <= 1'b0;
		stop_o <= 1'b1;
		wr_data_o <= ~wr_data_o; // Stale data must not look valid
		@(posedge ref_clk_i);
		stop_o <= 1'b0;
	endtask
endmodule

/* test/efc_core_tb.sv */
// Self-checking bench for the function command block
`timescale 1ns/1ns
`include "efc_consts.svh"
module efc_core_tb;
	localparam int P = 10;
	logic ref_clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic lock_arm_i = 1'b0;
	logic [7:0] rd_addr_i = 8'h00;
	logic wr_first_i, wr_byte_i, stop_i, rd_hit_o, wr_block_o, nv_copy_busy_o;
	logic [7:0] memory_pointer_i, wr_data_i, rd_data_o, c;
	logic [2:0] locked_o, copy_req_o, recall_req_o;
	logic [2:0] lk_q = 3'h0;
	logic [16:0] exp_q[$];
	int errors = 0;
	int n_tests = 0;
	int cyc = 0;
	int seed = 58832;
	wire logic [16:0] got = {copy_req_o, recall_req_o, locked_o, rd_hit_o ? rd_data_o : 8'h00};
	wire logic ev = (|copy_req_o) || (|recall_req_o) || rd_hit_o || (locked_o !== lk_q);
	always #50 ref_clk_i = ~ref_clk_i;
	efc_master u_m (.ref_clk_i(ref_clk_i), .wr_first_o(wr_first_i), .wr_byte_o(wr_byte_i),
		.memory_pointer_o(memory_pointer_i), .wr_data_o(wr_data_i), .stop_o(stop_i));
	efc_core #(.PROG_CYCLES(P), .HAS_UID(1'b1)) DUT (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
		.wr_first_i(wr_first_i), .wr_byte_i(wr_byte_i), .memory_pointer_i(memory_pointer_i),
		.wr_data_i(wr_data_i), .stop_i(stop_i), .rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o),
		.rd_hit_o(rd_hit_o), .lock_arm_i(lock_arm_i), .wr_block_o(wr_block_o),
		.nv_copy_busy_o(nv_copy_busy_o), .locked_o(locked_o), .copy_req_o(copy_req_o),
		.recall_req_o(recall_req_o));
	task automatic chk_gate(input logic e);
		@(negedge ref_clk_i);
		n_tests++;
		if (wr_block_o !== e)
		begin
			errors++;
			$display("unexpected at %0t: write gate %b", $time, wr_block_o);
		end
	endtask
	task automatic test_done();
		$display("tests %0d errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic cmd(input logic [7:0] code, input logic [16:0] e, input bit push);
		if (push)
			exp_q.push_back(e);
		u_m.write(`EFC_CMD_ADDR, code, 8'hB4, 1'b1);
		repeat (P + 6) @(posedge ref_clk_i);
		$display("test %h done", code);
	endtask
	always @(negedge ref_clk_i)
		if (rstn_i && ev)
		begin
			lk_q = locked_o;
			n_tests++;
			if (exp_q.size() == 0 || exp_q[0] !== got)
			begin
				errors++;
				$display("unexpected at %0t: result %h", $time, got);
			end
			if (exp_q.size() != 0)
				void'(exp_q.pop_front());
		end
	always @(posedge ref_clk_i)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			errors++;
			test_done();
		end
	end
	initial
	begin
		repeat (2) @(posedge ref_clk_i);
		rstn_i <= 1'b1;
		cmd(`EFC_COPY0, 17'h04000, 1'b1);
		cmd(`EFC_RCL1, 17'h01000, 1'b1);
		cmd(`EFC_LOCK0, 17'h00000, 1'b0);
		lock_arm_i <= 1'b1;
		cmd(`EFC_LOCK0, 17'h00100, 1'b1);
		cmd(`EFC_COPY0, 17'h00000, 1'b0);
		cmd(`EFC_COPY2, 17'h00000, 1'b0);
		cmd(`EFC_LOCK2, 17'h00000, 1'b0);
		cmd(`EFC_RCL2, 17'h00000, 1'b0);
		c = 8'($random(seed));
		if (c[7:4] inside {4'h4, 4'h6, 4'hB})
			c = 8'h11;
		cmd(c, 17'h00000, 1'b0);
		exp_q.push_back(17'h08100);
		u_m.write(`EFC_CMD_ADDR, `EFC_COPY1, 8'hB4, 1'b1);
		u_m.write(8'h30, 8'h00, 8'h00, 1'b0);
		chk_gate(1'b1);
		u_m.write(8'h50, 8'h00, 8'h00, 1'b0);
		chk_gate(1'b0);
		repeat (P + 6) @(posedge ref_clk_i);
		$display("test gate done");
		u_m.write(`EFC_ID_ADDR, 8'h00, 8'h00, 1'b1);
		chk_gate(1'b1);
		exp_q.push_back(17'h0015A);
		exp_q.push_back(17'h001A5);
		@(posedge ref_clk_i);
		rd_addr_i <= `EFC_ID_ADDR;
		@(posedge ref_clk_i);
		rd_addr_i <= 8'hF6;
		@(posedge ref_clk_i);
		rd_addr_i <= 8'hF8;
		repeat (4) @(posedge ref_clk_i);
		$display("test id done");
		n_tests++;
		if (exp_q.size() != 0)
		begin
			errors++;
			$display("unexpected at %0t: %0d results missing", $time, exp_q.size());
		end
		test_done();
	end
endmodule
bind efc_core efc_checker u_chk (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
	.wr_first_i(wr_first_i), .wr_byte_i(wr_byte_i), .memory_pointer_i(memory_pointer_i),
	.wr_data_i(wr_data_i), .stop_i(stop_i), .lock_arm_i(lock_arm_i), .rd_addr_i(rd_addr_i),
	.rd_hit_o(rd_hit_o), .nv_copy_busy_o(nv_copy_busy_o), .locked_o(locked_o),
	.copy_req_o(copy_req_o), .recall_req_o(recall_req_o));
